// [src/aics_pkg.sv]
// Overview of operation
// - Above maximum point, use maximum setting
// - Below minimum point, apply handling option
// - Curve one defaults 0.00 V/0%, 10.00 V/100%
// - Minimum point 0 to max; max to 10 V
// - Current input: 1 mA counts as 0.5 V
// - Per-channel low-pass filter, 0 to 10 s
// - Curves two, three independent, same behaviour
// - Pulse input scaled two-point, 0 to 50 kHz
// - Pulse frequency taken only from input five
// - Curve select digit per channel, default 321
// - Curves one-three two-point, four-five four-point
// - Below-min digit 0 minimum setting, 1 zero
// - Below-min handling digit per channel
// - Channel three only with extension card
// - Channel two voltage or current, voltage default
package aics_pkg;
    localparam int CLK_HZ       = 10_000_000;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYC     = TICK_TIME_US * (CLK_HZ / 1_000_000);
    localparam int GATE_TIME_MS = 100;
    localparam int GATE_CYC     = GATE_TIME_MS * (CLK_HZ / 1000);
    localparam int FILT_UNIT_MS = 10;
    localparam int AW           = 6;
    localparam int DW           = 16;

    // Register indices
    localparam logic [AW-1:0] IDX_C1     = 6'h00;
    localparam logic [AW-1:0] IDX_C2     = 6'h04;
    localparam logic [AW-1:0] IDX_C3     = 6'h08;
    localparam logic [AW-1:0] IDX_C4     = 6'h0C;
    localparam logic [AW-1:0] IDX_C5     = 6'h14;
    localparam logic [AW-1:0] IDX_PULSE  = 6'h1C;
    localparam logic [AW-1:0] IDX_FILT   = 6'h20;
    localparam logic [AW-1:0] IDX_SEL    = 6'h24;
    localparam logic [AW-1:0] IDX_BMIN   = 6'h25;
    localparam logic [AW-1:0] IDX_TYPE   = 6'h26;
    localparam int            NUM_CFG    = 39;
    localparam logic [AW-1:0] IDX_RES    = 6'h30;
    localparam logic [AW-1:0] IDX_STAT   = 6'h34;

    // Values: points in 0.01 V or 0.01 kHz, settings in 0.01 %
    localparam logic [DW-1:0] PT_V_MAX   = 16'h03E8;
    localparam logic [DW-1:0] PT_F_MAX   = 16'h1388;
    localparam logic [DW-1:0] SET_MAX    = 16'h2710;
    localparam logic [DW-1:0] SET_MIN    = 16'hD8F0;
    localparam logic [DW-1:0] FILT_DEF   = 16'h000A;
    localparam logic [DW-1:0] FILT_MAX   = 16'h03E8;
    localparam logic [DW-1:0] SEL_DEF    = 16'h0321;
    localparam logic [DW-1:0] BMIN_DEF   = 16'h0000;
    localparam logic [DW-1:0] P4_X1      = 16'h012C;
    localparam logic [DW-1:0] P4_Y1      = 16'h0BB8;
    localparam logic [DW-1:0] P4_X2      = 16'h0258;
    localparam logic [DW-1:0] P4_Y2      = 16'h1770;

    typedef struct packed {
        logic [DW-1:0] chan_three;
        logic [DW-1:0] chan_two;
        logic [DW-1:0] chan_one;
    } aics_samp_t;

    typedef struct packed {
        logic signed [DW-1:0] pulse;
        logic signed [DW-1:0] chan_three;
        logic signed [DW-1:0] chan_two;
        logic signed [DW-1:0] chan_one;
    } aics_pct_t;

    typedef enum logic [1:0] {ST_IDLE, ST_EVAL, ST_FILT} aics_state_t;

    function automatic logic [DW-1:0] aics_cfg_default(
        input logic [AW-1:0] idx);
        logic [DW-1:0] v;
        v = '0;
        case (idx)
            IDX_C1 + 6'h02, IDX_C2 + 6'h02, IDX_C3 + 6'h02: v = PT_V_MAX;
            IDX_C1 + 6'h03, IDX_C2 + 6'h03, IDX_C3 + 6'h03: v = SET_MAX;
            IDX_PULSE + 6'h02: v = PT_F_MAX;
            IDX_PULSE + 6'h03: v = SET_MAX;
            IDX_C4 + 6'h02, IDX_C5 + 6'h02: v = P4_X1;
            IDX_C4 + 6'h03, IDX_C5 + 6'h03: v = P4_Y1;
            IDX_C4 + 6'h04, IDX_C5 + 6'h04: v = P4_X2;
            IDX_C4 + 6'h05, IDX_C5 + 6'h05: v = P4_Y2;
            IDX_C4 + 6'h06, IDX_C5 + 6'h06: v = PT_V_MAX;
            IDX_C4 + 6'h07, IDX_C5 + 6'h07: v = SET_MAX;
            IDX_FILT, IDX_FILT + 6'h01, IDX_FILT + 6'h02,
            IDX_FILT + 6'h03: v = FILT_DEF;
            IDX_SEL:  v = SEL_DEF;
            IDX_BMIN: v = BMIN_DEF;
            default:  v = '0;
        endcase
        return v;
    endfunction : aics_cfg_default
endpackage : aics_pkg

// [src/aics_top.sv]
// Decided for this implementation: the register offsets and the address-and-strobe port.
module aics_top #(
    parameter int TICK_CYC_P = aics_pkg::TICK_CYC,
    parameter int GATE_CYC_P = aics_pkg::GATE_CYC
) (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rstn,
    // Register port
    input  wire logic [aics_pkg::AW-1:0] addr,
    input  wire logic [aics_pkg::DW-1:0] wr_data,
    input  wire logic                    wr_en,
    input  wire logic                    rd_en,
    output logic      [aics_pkg::DW-1:0] rd_data,
    // Converter samples, same clock
    input  wire aics_pkg::aics_samp_t    samp,
    // Pins
    input  wire logic                    digital_in_five,
    input  wire logic                    ext_card_present,
    // Scaled settings
    output aics_pkg::aics_pct_t          pct_out,
    output logic                         pct_update
);
    import aics_pkg::*;

    logic [DW-1:0]        cfg_r [0:NUM_CFG-1];
    logic [DW-1:0]        rd_data_r;
    logic [DW-1:0]        wr_val;
    logic                 dif_meta_r, dif_sync_r, dif_prev_r;
    logic                 ext_meta_r, ext_sync_r;
    logic [31:0]          tick_cnt_r;
    logic [31:0]          gate_cnt_r;
    logic [DW-1:0]        edge_cnt_r;
    logic [DW-1:0]        freq_r;
    aics_state_t          st_r;
    logic [1:0]           ch_r;
    logic signed [DW-1:0] target_r;
    logic signed [23:0]   acc_r [0:3];
    logic signed [23:0]   acc_nxt;
    logic                 upd_r;
    logic                 seen_wr_r;

    logic [DW-1:0]        x_in;
    logic [3:0]           digit;
    logic [2:0]           cv;
    logic [AW-1:0]        base;
    logic                 four;
    logic [DW-1:0]        px [0:3];
    logic signed [DW-1:0] py [0:3];
    logic                 bmin;
    logic [1:0]           seg;
    logic signed [33:0]   num;
    logic signed [33:0]   quo;
    logic signed [DW-1:0] target_nxt;

    // Pin synchronisers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dif_meta_r <= 1'b0;
            dif_sync_r <= 1'b0;
            dif_prev_r <= 1'b0;
            ext_meta_r <= 1'b0;
            ext_sync_r <= 1'b0;
        end else begin
            dif_meta_r <= digital_in_five;
            dif_sync_r <= dif_meta_r;
            dif_prev_r <= dif_sync_r;
            ext_meta_r <= ext_card_present;
            ext_sync_r <= ext_meta_r;
        end
    end

    // Frequency: rising edges in a 100 ms gate give 0.01 kHz units
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gate_cnt_r <= '0;
            edge_cnt_r <= '0;
            freq_r     <= '0;
        end else if (gate_cnt_r == 32'(GATE_CYC_P - 1)) begin
            gate_cnt_r <= '0;
            freq_r     <= edge_cnt_r;
            edge_cnt_r <= '0;
        end else begin
            gate_cnt_r <= gate_cnt_r + 32'h1;
            if (dif_sync_r && !dif_prev_r && edge_cnt_r != 16'hFFFF) begin
                edge_cnt_r <= edge_cnt_r + 16'h1;
            end
        end
    end

    // Write value, clamped so every two-point curve stays ordered; four-point curves only clamped to range
    always_comb begin
        wr_val = wr_data;
        if (addr < IDX_C4 || (addr >= IDX_PULSE && addr < IDX_FILT)) begin
            case (addr[1:0])
                2'h0: begin
                    if (wr_data > cfg_r[addr + 6'h02]) begin
                        wr_val = cfg_r[addr + 6'h02];
                    end
                end
                2'h2: begin
                    if (wr_data < cfg_r[addr - 6'h02]) begin
                        wr_val = cfg_r[addr - 6'h02];
                    end else if (addr >= IDX_PULSE && wr_data > PT_F_MAX) begin
                        wr_val = PT_F_MAX;
                    end else if (addr < IDX_PULSE && wr_data > PT_V_MAX) begin
                        wr_val = PT_V_MAX;
                    end
                end
                default: begin
                    if ($signed(wr_data) > $signed(SET_MAX)) begin
                        wr_val = SET_MAX;
                    end else if ($signed(wr_data) < $signed(SET_MIN)) begin
                        wr_val = SET_MIN;
                    end
                end
            endcase
        end else if (addr < IDX_PULSE) begin
            if (!addr[0] && wr_data > PT_V_MAX) begin
                wr_val = PT_V_MAX;
            end else if (addr[0] && $signed(wr_data) > $signed(SET_MAX)) begin
                wr_val = SET_MAX;
            end else if (addr[0] && $signed(wr_data) < $signed(SET_MIN)) begin
                wr_val = SET_MIN;
            end
        end else if (addr < IDX_SEL && wr_data > FILT_MAX) begin
            wr_val = FILT_MAX;
        end
    end

    // Configuration store; defaults give curve 1 as 0 V..10 V to 0..100 %
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_CFG; i++) begin
                cfg_r[i] <= aics_cfg_default(AW'(i));
            end
        end else if (wr_en && addr < AW'(NUM_CFG)) begin
            cfg_r[addr] <= wr_val;
        end
    end

    // Read data in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_r <= '0;
        end else begin
            rd_data_r <= '0;
            if (rd_en && addr < AW'(NUM_CFG)) begin
                rd_data_r <= cfg_r[addr];
            end else if (rd_en && addr >= IDX_RES && addr < IDX_STAT) begin
                rd_data_r <= acc_r[addr[1:0]][23:8];
            end else if (rd_en && addr == IDX_STAT) begin
                rd_data_r <= {14'h0000, st_r != ST_IDLE, ext_sync_r};
            end
        end
    end

    // Curve evaluation for the channel in turn
    always_comb begin
        case (ch_r)
            2'h0: x_in = samp.chan_one;
            2'h1: x_in = cfg_r[IDX_TYPE][0] ? {1'b0, samp.chan_two[15:1]}
                                             : samp.chan_two;
            2'h2: x_in = samp.chan_three;
            default: x_in = freq_r;
        endcase
        digit = cfg_r[IDX_SEL][{ch_r, 2'b00} +: 4];
        if (ch_r == 2'h3) begin
            cv = 3'h5;
        end else if (digit >= 4'h1 && digit <= 4'h5) begin
            cv = 3'(digit - 4'h1);
        end else begin
            cv = 3'h0;
        end
        case (cv)
            3'h0: base = IDX_C1;
            3'h1: base = IDX_C2;
            3'h2: base = IDX_C3;
            3'h3: base = IDX_C4;
            3'h4: base = IDX_C5;
            default: base = IDX_PULSE;
        endcase
        four = (cv == 3'h3 || cv == 3'h4);
        // A two-point curve is spread as four points, last three equal
        for (int k = 0; k < 4; k++) begin
            if (four) begin
                px[k] = cfg_r[base + AW'(2 * k)];
                py[k] = cfg_r[base + AW'(2 * k + 1)];
            end else if (k == 0) begin
                px[k] = cfg_r[base];
                py[k] = cfg_r[base + 6'h01];
            end else begin
                px[k] = cfg_r[base + 6'h02];
                py[k] = cfg_r[base + 6'h03];
            end
        end
        bmin = (ch_r == 2'h3) ? 1'b0 : cfg_r[IDX_BMIN][{ch_r, 2'b00}];
        seg = 2'h2;
        for (int k = 2; k >= 0; k--) begin
            if (x_in < px[k + 1]) begin
                seg = 2'(k);
            end
        end
        num = 34'(py[seg + 2'h1] - py[seg])
            * 34'($signed({2'b00, x_in - px[seg]}));
        if (px[seg + 2'h1] == px[seg]) begin
            quo = '0;
        end else begin
            quo = num / 34'($signed({2'b00, px[seg + 2'h1] - px[seg]}));
        end
        if (x_in < px[0]) begin
            target_nxt = bmin ? '0 : py[0];
        end else if (x_in >= px[3]) begin
            target_nxt = py[3];
        end else begin
            target_nxt = py[seg] + quo[15:0];
        end
        if (ch_r == 2'h2 && !ext_sync_r) begin
            target_nxt = '0;
        end
    end

    // First-order low-pass, one step per millisecond
    always_comb begin
        logic signed [24:0] diff;
        logic signed [24:0] step;
        logic [DW-1:0]      tau;
        // Sign kept so negative settings are filtered the right way
        diff = 25'($signed({target_r, 8'h00})) - 25'(acc_r[ch_r]);
        tau  = cfg_r[IDX_FILT + AW'(ch_r)];
        step = diff;
        if (tau != '0) begin
            step = diff / 25'($signed({1'b0, tau * 16'(FILT_UNIT_MS)}));
        end
        acc_nxt = acc_r[ch_r] + step[23:0];
        if (ch_r == 2'h2 && !ext_sync_r) begin
            acc_nxt = '0;
        end
    end

    // Sequencer walks the four channels once per tick
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_r <= '0;
            st_r       <= ST_IDLE;
            ch_r       <= '0;
            target_r   <= '0;
            upd_r      <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                acc_r[i] <= '0;
            end
        end else begin
            upd_r      <= 1'b0;
            tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYC_P - 1))
                        ? '0 : tick_cnt_r + 32'h1;
            case (st_r)
                ST_IDLE: begin
                    if (tick_cnt_r == 32'(TICK_CYC_P - 1)) begin
                        st_r <= ST_EVAL;
                        ch_r <= '0;
                    end
                end
                ST_EVAL: begin
                    target_r <= target_nxt;
                    st_r     <= ST_FILT;
                end
                ST_FILT: begin
                    acc_r[ch_r] <= acc_nxt;
                    if (ch_r == 2'h3) begin
                        st_r  <= ST_IDLE;
                        upd_r <= 1'b1;
                    end else begin
                        ch_r <= ch_r + 2'h1;
                        st_r <= ST_EVAL;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Helper for checks: set on the first register write
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            seen_wr_r <= 1'b0;
        end else if (wr_en) begin
            seen_wr_r <= 1'b1;
        end
    end

    assign rd_data            = rd_data_r;
    assign pct_update         = upd_r;
    assign pct_out.chan_one   = acc_r[0][23:8];
    assign pct_out.chan_two   = acc_r[1][23:8];
    assign pct_out.chan_three = acc_r[2][23:8];
    assign pct_out.pulse      = acc_r[3][23:8];

    property p_clamp_max;
        @(posedge sys_clk) disable iff (!rstn)
        (st_r == ST_EVAL && x_in >= px[3] && !(ch_r == 2'h2 && !ext_sync_r))
        |=> target_r == $past(py[3]);
    endproperty
    a_clamp_max: assert property (p_clamp_max)
        else $error("over-range input not clamped");
    property p_below_min;
        @(posedge sys_clk) disable iff (!rstn)
        (st_r == ST_EVAL && x_in < px[0] && ch_r != 2'h2)
        |=> target_r == ($past(bmin) ? 16'sh0000 : $past(py[0]));
    endproperty
    a_below_min: assert property (p_below_min)
        else $error("below-minimum result wrong");
    property p_interp_bound;
        @(posedge sys_clk) disable iff (!rstn)
        (st_r == ST_EVAL && !four && ch_r != 2'h2
            && x_in >= px[0] && x_in < px[3] && py[0] <= py[3])
        |=> target_r >= $past(py[0]) && target_r <= $past(py[3]);
    endproperty
    a_interp_bound: assert property (p_interp_bound)
        else $error("interpolation outside end settings");
    property p_default_curve;
        @(posedge sys_clk) disable iff (!rstn)
        !seen_wr_r |-> cfg_r[IDX_C1 + 6'h02] == PT_V_MAX
            && cfg_r[IDX_C1 + 6'h03] == SET_MAX && cfg_r[IDX_C1] == '0;
    endproperty
    a_default_curve: assert property (p_default_curve)
        else $error("curve one default lost");
    property p_point_order;
        @(posedge sys_clk) disable iff (!rstn)
        cfg_r[IDX_C1] <= cfg_r[IDX_C1 + 6'h02]
            && cfg_r[IDX_C1 + 6'h02] <= PT_V_MAX;
    endproperty
    a_point_order: assert property (p_point_order)
        else $error("curve one points out of order");
    property p_current_scale;
        @(posedge sys_clk) disable iff (!rstn)
        (st_r == ST_EVAL && ch_r == 2'h1 && cfg_r[IDX_TYPE][0])
        |-> x_in == {1'b0, samp.chan_two[15:1]};
    endproperty
    a_current_scale: assert property (p_current_scale)
        else $error("current input not halved");
    property p_filter_zero;
        @(posedge sys_clk) disable iff (!rstn)
        (st_r == ST_FILT && cfg_r[IDX_FILT + AW'(ch_r)] == '0
            && ch_r != 2'h2)
        |=> acc_r[$past(ch_r)][23:8] == $past(target_r);
    endproperty
    a_filter_zero: assert property (p_filter_zero)
        else $error("zero filter time did not pass through");
    property p_freq_latch;
        @(posedge sys_clk) disable iff (!rstn)
        (gate_cnt_r == 32'(GATE_CYC_P - 1)) |=> freq_r == $past(edge_cnt_r)
            ##1 edge_cnt_r <= 16'h0001;
    endproperty
    a_freq_latch: assert property (p_freq_latch)
        else $error("pulse count not latched");
    property p_no_card;
        @(posedge sys_clk) disable iff (!rstn)
        (!ext_sync_r && st_r == ST_FILT && ch_r == 2'h2)
        |=> pct_out.chan_three == '0;
    endproperty
    a_no_card: assert property (p_no_card)
        else $error("channel three active without card");
    property p_curve_pick;
        @(posedge sys_clk) disable iff (!rstn)
        (ch_r != 2'h3 && digit == 4'h4) |-> four && base == IDX_C4;
    endproperty
    a_curve_pick: assert property (p_curve_pick)
        else $error("curve four not selected");
endmodule : aics_top

// [verification/aics_far_model.sv]
module aics_far_model (
    // Clock
    input  wire logic                 sys_clk,
    // Bench settings
    input  wire aics_pkg::aics_samp_t level_set,
    input  wire logic [7:0]           pulse_half,
    // Converter and pin side
    output aics_pkg::aics_samp_t      samp,
    output logic                      digital_in_five
);
    timeunit 1ns;
    timeprecision 1ns;
    import aics_pkg::*;

    logic [7:0] half_cnt = 8'h00;

    // Converters deliver a fresh sample every clock
    always @(posedge sys_clk) begin
        samp <= level_set;
    end

    // Pulse source sits still low when stopped, so no stray edge is counted
    always @(posedge sys_clk) begin
        if (pulse_half == 8'h00) begin
            half_cnt        <= 8'h00;
            digital_in_five <= 1'b0;
        end else if (half_cnt == pulse_half - 8'h01) begin
            half_cnt        <= 8'h00;
            digital_in_five <= ~digital_in_five;
        end else begin
            half_cnt <= half_cnt + 8'h01;
        end
    end
endmodule : aics_far_model

// [verification/test_analog_input_curve_scaling.sv]
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end

module test_analog_input_curve_scaling;
    timeunit 1ns;
    timeprecision 1ns;
    import aics_pkg::*;

    logic          sys_clk = 1'b0;
    logic          rstn    = 1'b0;
    logic [AW-1:0] addr    = '0;
    logic [DW-1:0] wr_data = '0;
    logic          wr_en   = 1'b0;
    logic          rd_en   = 1'b0;
    logic [DW-1:0] rd_data;
    aics_samp_t    samp;
    aics_samp_t    lv      = '0;
    logic          din5;
    logic          card    = 1'b1;
    logic [7:0]    phalf   = 8'h00;
    aics_pct_t     pct_out;
    logic          pct_update;
    int            mismatches  = 0;
    int            checks_done = 0;
    logic [31:0]   seed    = 32'h6CE9C021;
    int            x1, x2, x3;
    int            filt;

    always #50 sys_clk = ~sys_clk;

    // Short tick and gate keep the run brief
    aics_top #(.TICK_CYC_P(20), .GATE_CYC_P(200)) aics_top_i (
        .sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .samp(samp),
        .digital_in_five(din5), .ext_card_present(card),
        .pct_out(pct_out), .pct_update(pct_update));

    aics_far_model aics_far_model_i (
        .sys_clk(sys_clk), .level_set(lv), .pulse_half(phalf),
        .samp(samp), .digital_in_five(din5));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    function automatic logic [DW-1:0] two_pt(input int x, x0, y0, x1, y1,
                                             input bit zb);
        if (x >= x1) return DW'(y1);
        if (x < x0) return zb ? '0 : DW'(y0);
        return DW'(y0 + (x - x0) * (y1 - y0) / (x1 - x0));
    endfunction : two_pt

    task automatic final_report;
        if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge sys_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge sys_clk);
        wr_en   <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        @(negedge sys_clk);
        `CHK(rd_data, e)
    endtask : rdc

    task automatic wait_upd;
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (pct_update !== 1'b1 && n < 200);
        `CHK(pct_update, 1'b1)
    endtask : wait_upd

    // Two sweeps so every channel has seen the new samples
    task automatic settle(input int a, b, c);
        @(posedge sys_clk);
        lv <= {DW'(c), DW'(b), DW'(a)};
        wait_upd;
        wait_upd;
    endtask : settle

    initial begin
        // Ten thousand cycles, a few times the whole run
        #1_000_000;
        mismatches++;
        final_report;
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        rdc(IDX_SEL, 16'h0321);
        rdc(IDX_BMIN, 16'h0000);
        rdc(IDX_C1, 16'h0000);
        rdc(IDX_C1 + 6'h02, 16'h03E8);
        rdc(IDX_C1 + 6'h03, 16'h2710);
        rdc(IDX_FILT, 16'h000A);
        rdc(IDX_PULSE + 6'h02, 16'h1388);
        rdc(IDX_C3 + 6'h02, 16'h03E8);
        wr(6'h27, 16'h1234);
        rdc(6'h27, 16'h0000);
        wr(IDX_C1 + 6'h02, 16'h07D0);
        rdc(IDX_C1 + 6'h02, 16'h03E8);
        for (int i = 0; i < 4; i++) wr(IDX_FILT + 6'(i), 16'h0000);
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            x1 = int'(seed[10:0]) % 1201;
            seed = xs(seed);
            x2 = int'(seed[10:0]) % 1201;
            seed = xs(seed);
            x3 = int'(seed[10:0]) % 1201;
            settle(x1, x2, x3);
            `CHK(pct_out.chan_one, two_pt(x1, 0, 0, 1000, 10000, 0))
            `CHK(pct_out.chan_two, two_pt(x2, 0, 0, 1000, 10000, 0))
            `CHK(pct_out.chan_three, two_pt(x3, 0, 0, 1000, 10000, 0))
        end
        wr(IDX_C1, 16'h00C8);
        wr(IDX_C1 + 6'h01, 16'hEC78);
        wr(IDX_C2, 16'h0064);
        wr(IDX_C2 + 6'h01, 16'h07D0);
        settle(216, 50, 1000);
        `CHK(pct_out.chan_one, 16'hEDA4)
        `CHK(pct_out.chan_two, 16'h07D0)
        `CHK(pct_out.chan_three, 16'h2710)
        settle(100, 50, 500);
        `CHK(pct_out.chan_one, 16'hEC78)
        wr(IDX_BMIN, 16'h0001);
        settle(100, 50, 500);
        `CHK(pct_out.chan_one, 16'h0000)
        `CHK(pct_out.chan_two, 16'h07D0)
        `CHK(pct_out.chan_three, 16'h1388)
        wr(IDX_BMIN, 16'h0010);
        settle(100, 50, 500);
        `CHK(pct_out.chan_one, 16'hEC78)
        `CHK(pct_out.chan_two, 16'h0000)
        wr(IDX_SEL, 16'h0111);
        settle(100, 216, 216);
        `CHK(pct_out.chan_two, 16'hEDA4)
        `CHK(pct_out.chan_three, 16'hEDA4)
        wr(IDX_C4 + 6'h05, 16'h2328);
        wr(IDX_SEL, 16'h0444);
        settle(450, 800, 1100);
        `CHK(pct_out.chan_one, 16'h1770)
        `CHK(pct_out.chan_two, 16'h251C)
        `CHK(pct_out.chan_three, 16'h2710)
        wr(IDX_SEL, 16'h0321);
        wr(IDX_C2, 16'h0000);
        wr(IDX_C2 + 6'h01, 16'h0000);
        wr(IDX_TYPE, 16'h0001);
        settle(0, 1200, 0);
        `CHK(pct_out.chan_two, 16'h1770)
        @(posedge sys_clk);
        card <= 1'b0;
        settle(0, 0, 500);
        `CHK(pct_out.chan_three, 16'h0000)
        @(posedge sys_clk);
        card  <= 1'b1;
        phalf <= 8'h04;
        repeat (700) @(posedge sys_clk);
        wait_upd;
        `CHK(pct_out.pulse >= 48 && pct_out.pulse <= 52, 1'b1)
        phalf <= 8'h00;
        repeat (700) @(posedge sys_clk);
        wait_upd;
        `CHK(pct_out.pulse, 16'h0000)
        settle(0, 0, 0);
        `CHK(pct_out.chan_one, 16'hEC78)
        // One or two filter steps of a tenth, depending on sweep phase
        wr(IDX_FILT, 16'h0001);
        settle(1000, 0, 0);
        filt = pct_out.chan_one;
        `CHK(filt >= -3500 && filt <= -2150, 1'b1)
        wr(IDX_FILT, 16'h0000);
        settle(1000, 0, 0);
        `CHK(pct_out.chan_one, 16'h2710)
        rdc(IDX_RES, 16'h2710);
        rdc(IDX_STAT, 16'h0001);
        // Falling toward a negative setting through the filter
        wr(IDX_FILT, 16'h0001);
        settle(0, 0, 0);
        filt = pct_out.chan_one;
        `CHK(filt >= 7150 && filt <= 8500, 1'b1)
        // Reset in mid-run brings the defaults back
        @(posedge sys_clk);
        rstn <= 1'b0;
        @(posedge sys_clk);
        rstn <= 1'b1;
        `CHK(pct_out.chan_one, 16'h0000)
        rdc(IDX_FILT, 16'h000A);
        rdc(IDX_C1, 16'h0000);
        rdc(IDX_C1 + 6'h01, 16'h0000);
        final_report;
    end
endmodule : test_analog_input_curve_scaling
